// file: verilog/fts_defines.vh
`ifndef FTS_DEFINES_VH
`define FTS_DEFINES_VH

// ****************************************
// Register indexes, byte address is four times these
// ****************************************
`define FTS_IDX_FAN 8'h56
`define FTS_IDX_CLK_CTL 8'h58
`define FTS_IDX_TACH_COUNT 8'h59
`define FTS_IDX_TACH_PRELOAD 8'h5b

// ****************************************
// Reset values
// ****************************************
`define FTS_RST_FAN 8'h00
`define FTS_RST_CLK_CTL 8'h10
`define FTS_RST_TACH_COUNT 8'h00
`define FTS_RST_TACH_PRELOAD 8'h00

// ****************************************
// Field positions
// ****************************************
`define FTS_CTL_SRC_BIT 0
`define FTS_CTL_MULT_BIT 2
`define FTS_CTL_DIV_HI 5
`define FTS_CTL_DIV_LO 4
`define FTS_CTL_WR_MASK 8'h35
`define FTS_FAN_FORCE_BIT 0
`define FTS_FAN_DUTY_HI 6
`define FTS_FAN_DUTY_LO 1
`define FTS_FAN_CLKSEL_BIT 7

// ****************************************
// Counter limits
// ****************************************
`define FTS_TACH_MAX 8'hff
`define FTS_PWM_LAST 6'h3f
`define FTS_DIV_1 4'h1
`define FTS_DIV_2 4'h2
`define FTS_DIV_4 4'h4
`define FTS_DIV_8 4'h8

`endif

// file: verilog/fts_top.v
`timescale 1ns/1ns
`include "fts_defines.vh"

module fts_top #(
    parameter [7:0] FAN_STEP_00 = 8'h80,
    parameter [7:0] FAN_STEP_01 = 8'h40,
    parameter [7:0] FAN_STEP_10 = 8'h20,
    parameter [7:0] FAN_STEP_11 = 8'h10
) (
    input wire ref_clk,
    input wire rst,
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire fan_tach_in,
    output reg fan_drive_out
);

    // ****************************************
    // Helper functions
    // ****************************************
    function [7:0] fts_step_len;
        input clk_sel;
        input src_sel;
        input mult;
        reg [7:0] base;
        reg [7:0] len;
        begin
            case ({clk_sel, src_sel})
                2'b00: base = FAN_STEP_00;
                2'b01: base = FAN_STEP_01;
                2'b10: base = FAN_STEP_10;
                default: base = FAN_STEP_11;
            endcase
            // Halving the step length doubles the output rate
            if (mult) begin
                len = {1'b0, base[7:1]};
            end else begin
                len = base;
            end
            // A zero length would wrap the compare to 8'hff and stretch each step to 256 counts
            if (len == 8'h00) begin
                len = 8'h01;
            end
            fts_step_len = len;
        end
    endfunction

    function [3:0] fts_div_len;
        input [1:0] div_sel;
        begin
            case (div_sel)
                2'b00: fts_div_len = `FTS_DIV_1;
                2'b01: fts_div_len = `FTS_DIV_2;
                2'b10: fts_div_len = `FTS_DIV_4;
                default: fts_div_len = `FTS_DIV_8;
            endcase
        end
    endfunction

    // One-hot hit on the four implemented registers, shared by read and write
    function [3:0] fts_reg_sel;
        input [7:0] idx;
        begin
            case (idx)
                `FTS_IDX_FAN: fts_reg_sel = 4'h1;
                `FTS_IDX_CLK_CTL: fts_reg_sel = 4'h2;
                `FTS_IDX_TACH_COUNT: fts_reg_sel = 4'h4;
                `FTS_IDX_TACH_PRELOAD: fts_reg_sel = 4'h8;
                default: fts_reg_sel = 4'h0;
            endcase
        end
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    reg ack_q;
    wire ack_d;
    reg [7:0] fan_q;
    reg [7:0] clk_ctl_q;
    reg [7:0] tach_count_q;
    reg [7:0] tach_preload_q;
    reg [7:0] step_cnt_q;
    reg [7:0] step_cnt_d;
    reg [5:0] phase_q;
    reg [5:0] phase_d;
    reg fan_drive_d;
    reg tach_meta_q;
    reg tach_sync_q;
    reg tach_prev_q;
    reg [7:0] tach_run_q;
    reg [7:0] tach_run_d;
    reg [3:0] tach_div_cnt_q;
    reg [3:0] tach_div_cnt_d;
    reg [7:0] tach_count_d;
    reg [31:0] readdata_d;
    wire [7:0] reg_index;
    wire [3:0] reg_sel;
    wire bus_req;
    wire wr_commit;
    wire wr_low;
    wire wr_fan;
    wire wr_ctl;
    wire wr_preload;
    wire [7:0] step_len;
    wire step_tick;
    wire [3:0] div_len;
    wire div_tick;
    wire tach_edge;
    wire [5:0] duty;

    // ****************************************
    // Avalon slave
    // ****************************************
    assign reg_index = avs_address[9:2];
    assign reg_sel = fts_reg_sel(reg_index);
    assign bus_req = avs_read | avs_write;
    // One wait state, so read data is settled before waitrequest drops
    assign avs_waitrequest = bus_req & ~ack_q;
    assign ack_d = bus_req & ~ack_q;
    assign wr_commit = avs_write & ack_q;
    assign wr_low = wr_commit & avs_byteenable[0];
    // Writes to the count register and to holes fall through here
    assign wr_fan = wr_low & reg_sel[0];
    assign wr_ctl = wr_low & reg_sel[1];
    assign wr_preload = wr_low & reg_sel[3];

    always @* begin
        readdata_d = avs_readdata;
        if (avs_read & ~ack_q) begin
            readdata_d = 32'h0000_0000;
            case (reg_sel)
                4'h1: begin
                    readdata_d[7:0] = fan_q;
                end
                4'h2: begin
                    readdata_d[7:0] = clk_ctl_q;
                end
                4'h4: begin
                    readdata_d[7:0] = tach_count_q;
                end
                4'h8: begin
                    readdata_d[7:0] = tach_preload_q;
                end
                default: begin
                    readdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            avs_readdata <= readdata_d;
        end
    end

    // ****************************************
    // Control registers, loaded with their reset values (clock control 8'h10) by standby power-on reset
    // ****************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            fan_q <= `FTS_RST_FAN;
            clk_ctl_q <= `FTS_RST_CLK_CTL;
            tach_preload_q <= `FTS_RST_TACH_PRELOAD;
        end else begin
            if (wr_fan) begin
                fan_q <= avs_writedata[7:0];
            end
            if (wr_ctl) begin
                // Reserved bits are kept at zero
                clk_ctl_q <= avs_writedata[7:0] & `FTS_CTL_WR_MASK;
            end
            if (wr_preload) begin
                tach_preload_q <= avs_writedata[7:0];
            end
        end
    end

    // ****************************************
    // Fan drive generator
    // ****************************************
    assign step_len = fts_step_len(fan_q[`FTS_FAN_CLKSEL_BIT],
                                   clk_ctl_q[`FTS_CTL_SRC_BIT],
                                   clk_ctl_q[`FTS_CTL_MULT_BIT]);
    assign step_tick = (step_cnt_q >= step_len - 8'h01);
    assign duty = fan_q[`FTS_FAN_DUTY_HI:`FTS_FAN_DUTY_LO];

    always @* begin
        step_cnt_d = step_cnt_q + 8'h01;
        phase_d = phase_q;
        if (step_tick) begin
            // Compare with >= so a shorter new length takes effect at once
            step_cnt_d = 8'h00;
            phase_d = phase_q + 6'h01;
        end
    end

    always @* begin
        if (fan_q[`FTS_FAN_FORCE_BIT]) begin
            fan_drive_d = 1'b1;
        end else begin
            // Duty 0 never beats the phase, duty 63 loses only phase 63
            fan_drive_d = (phase_q < duty);
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            step_cnt_q <= 8'h00;
            phase_q <= 6'h00;
            fan_drive_out <= 1'b0;
        end else begin
            step_cnt_q <= step_cnt_d;
            phase_q <= phase_d;
            fan_drive_out <= fan_drive_d;
        end
    end

    // ****************************************
    // Tachometer input synchroniser
    // ****************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            tach_meta_q <= 1'b0;
            tach_sync_q <= 1'b0;
            tach_prev_q <= 1'b0;
        end else begin
            // Nothing but the second flop reads the first, which may go metastable
            tach_meta_q <= fan_tach_in;
            tach_sync_q <= tach_meta_q;
            tach_prev_q <= tach_sync_q;
        end
    end

    // Rising edges mark pulse boundaries
    // A pin already high at reset release gives one edge that latches one
    assign tach_edge = tach_sync_q & ~tach_prev_q;

    // ****************************************
    // Tachometer counter
    // ****************************************
    assign div_len = fts_div_len(clk_ctl_q[`FTS_CTL_DIV_HI:`FTS_CTL_DIV_LO]);
    assign div_tick = (tach_div_cnt_q >= div_len - 4'h1);

    always @* begin
        tach_run_d = tach_run_q;
        tach_div_cnt_d = tach_div_cnt_q + 4'h1;
        tach_count_d = tach_count_q;
        if (tach_edge) begin
            tach_count_d = tach_run_q;
        end
        if (wr_preload) begin
            // Reading stays doubtful for one pulse after this restart
            tach_run_d = avs_writedata[7:0];
            tach_div_cnt_d = 4'h0;
        end else if (tach_edge) begin
            tach_run_d = tach_preload_q;
            tach_div_cnt_d = 4'h0;
        end else if (div_tick) begin
            tach_div_cnt_d = 4'h0;
            if (tach_run_q != `FTS_TACH_MAX) begin
                tach_run_d = tach_run_q + 8'h01;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            tach_run_q <= 8'h00;
            tach_div_cnt_q <= 4'h0;
            tach_count_q <= `FTS_RST_TACH_COUNT;
        end else begin
            tach_run_q <= tach_run_d;
            tach_div_cnt_q <= tach_div_cnt_d;
            tach_count_q <= tach_count_d;
        end
    end

endmodule // fts_top

// file: tb/fts_monitor.sv
`timescale 1ns/1ns
// ****
// Bus and drive checks
// ****
module fts_monitor (
    input wire ref_clk,
    input wire rst,
    input wire [9:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire fan_drive_out
);
    wire [7:0] ix = avs_address[9:2];
    wire rd = avs_read && !avs_waitrequest;
    wire wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    reg [7:0] fan_q;
    reg [7:0] ctl_q;
    reg [7:0] pre_q;
    reg [1:0] age_q;
    // Shadow copies, age counts cycles since a fan register write
    always @(posedge ref_clk) begin
        if (rst) begin
            fan_q <= 8'h00;
            ctl_q <= 8'h10;
            pre_q <= 8'h00;
            age_q <= 2'h0;
        end else begin
            if (wr && ix == 8'h56) fan_q <= avs_writedata[7:0];
            if (wr && ix == 8'h58) ctl_q <= avs_writedata[7:0] & 8'h35;
            if (wr && ix == 8'h5b) pre_q <= avs_writedata[7:0];
            age_q <= (wr && ix == 8'h56) ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    one_wait_a: assert property (req_s |=> !avs_waitrequest) else $error("no answer");
    ack_pulse_a: assert property (rd |=> avs_waitrequest || !avs_read) else $error("ack");
    upper_zero_a: assert property (rd |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("hi");
    fan_back_a: assert property (rd && ix == 8'h56 |-> avs_readdata[7:0] == fan_q)
        else $error("fan");
    ctl_back_a: assert property (rd && ix == 8'h58 |-> avs_readdata[7:0] == ctl_q)
        else $error("ctl");
    pre_back_a: assert property (rd && ix == 8'h5b |-> avs_readdata[7:0] == pre_q)
        else $error("pre");
    hole_zero_a: assert property (rd && ix != 8'h56 && ix != 8'h58
        && ix != 8'h59 && ix != 8'h5b |-> avs_readdata == 32'h0000_0000) else $error("hole");
    force_high_a: assert property (fan_q[0] && age_q == 2'h3 |-> fan_drive_out)
        else $error("frc");
    duty_low_a: assert property (fan_q[6:0] == 7'h00 && age_q == 2'h3 |-> !fan_drive_out)
        else $error("low");
endmodule // fts_monitor

// file: tb/fts_fan_model.sv
`timescale 1ns/1ns
// ****
// Fan tach, toggles every half_clks clocks, zero stops it
// ****
module fts_fan_model (
    input wire ref_clk,
    input wire [15:0] half_clks,
    output reg fan_tach_in = 1'b0
);
    reg [15:0] cnt_q = 16'h0000;
    always @(posedge ref_clk) begin
        cnt_q <= (cnt_q >= half_clks) ? 16'h0001 : cnt_q + 16'h0001;
        if (cnt_q >= half_clks && half_clks != 16'h0000) fan_tach_in <= !fan_tach_in;
    end
endmodule // fts_fan_model

// file: tb/fts_top_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
// ****
// Scenarios
// ****
module fts_top_tb;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [9:0] avs_address = 10'h000;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0000_0000;
    reg [3:0] avs_byteenable = 4'h0;
    reg [15:0] half_clks = 16'h0000;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire fan_tach_in;
    wire fan_drive_out;
    integer fail_count = 0;
    integer checks_done = 0;
    integer k;
    integer per;
    integer hi;
    reg [7:0] v;
    always #50 ref_clk = !ref_clk;
    fts_top #(.FAN_STEP_00(8'h08), .FAN_STEP_01(8'h06), .FAN_STEP_10(8'h04), .FAN_STEP_11(8'h02))
        u_fts_top (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fan_tach_in(fan_tach_in), .fan_drive_out(fan_drive_out));
    fts_fan_model u_fts_fan_model (.ref_clk(ref_clk), .half_clks(half_clks),
        .fan_tach_in(fan_tach_in));
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task bus(input w, input [7:0] i, input [7:0] d, input [3:0] be);
        begin
            @(posedge ref_clk);
            avs_address <= {i, 2'b00};
            avs_writedata <= {24'h00_0000, d};
            avs_byteenable <= be;
            avs_write <= w;
            avs_read <= !w;
            @(posedge ref_clk);
            while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
            v = avs_readdata[7:0];
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task t_regs;
        begin
            bus(0, 8'h56, 8'h00, 4'h1);
            `CHK("fan", 8'h00, v)
            bus(0, 8'h58, 8'h00, 4'h1);
            `CHK("ctl", 8'h10, v)
            bus(0, 8'h5b, 8'h00, 4'h1);
            `CHK("pre", 8'h00, v)
            bus(1, 8'h58, 8'hff, 4'h1);
            bus(1, 8'h58, 8'h00, 4'h0);
            bus(1, 8'h59, 8'h5a, 4'h1);
            bus(0, 8'h58, 8'h00, 4'h1);
            `CHK("ctl_mask", 8'h35, v)
            bus(0, 8'h59, 8'h00, 4'h1);
            `CHK("cnt_ro", 8'h00, v)
            bus(0, 8'h5a, 8'h00, 4'h1);
            `CHK("hole", 8'h00, v)
            bus(1, 8'h56, 8'h01, 4'h1);
            repeat (9) @(negedge ref_clk);
            `CHK("force", 1'b1, fan_drive_out)
            bus(1, 8'h56, 8'h00, 4'h1);
            repeat (9) @(negedge ref_clk);
            `CHK("zero", 1'b0, fan_drive_out)
        end
    endtask
    task t_tach(input [1:0] dv, input [7:0] p, input [15:0] h, input [7:0] e);
        begin
            half_clks <= h;
            bus(1, 8'h58, {2'b00, dv, 4'h0}, 4'h1);
            bus(1, 8'h5b, p, 4'h1);
            repeat (8 * h) @(posedge ref_clk); // Skip stale pulses
            bus(0, 8'h59, 8'h00, 4'h1);
            `CHK("tach", 1'b1, v - e + 8'h01 <= 8'h02)
            e = v;
            bus(0, 8'h59, 8'h00, 4'h1);
            `CHK("latch", e, v)
        end
    endtask
    // First period after a change is skipped, it may be cut short
    task t_fan(input [2:0] m, input [5:0] d, input integer l);
        begin
            bus(1, 8'h56, {m[2], d, 1'b0}, 4'h1);
            bus(1, 8'h58, {5'h02, m[0], 1'b0, m[1]}, 4'h1);
            @(posedge fan_drive_out);
            @(posedge fan_drive_out);
            per = 0;
            hi = 0;
            do begin
                @(negedge ref_clk);
                per = per + 1;
                hi = hi + fan_drive_out;
            end while (!(fan_drive_out && per > hi));
            `CHK("period", 64 * l, per - 1)
            `CHK("high", d * l, hi - 1)
        end
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs;
        t_tach(2'h0, 8'h10, 16'd40, 8'h60);
        t_tach(2'h1, 8'h10, 16'd40, 8'h38);
        t_tach(2'h2, 8'h10, 16'd40, 8'h24);
        t_tach(2'h3, 8'h10, 16'd40, 8'h1a);
        t_tach(2'h1, 8'ha0, 16'd120, 8'hff);
        for (k = 0; k < 8; k = k + 1) t_fan(k[2:0], 6'h20, (8 - 2 * k[2:1]) >> k[0]);
        t_fan(3'h0, 6'h3f, 8);
        end_sim;
    end
endmodule // fts_top_tb
bind fts_top fts_monitor u_fts_monitor (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fan_drive_out(fan_drive_out));
